//--- core/isr_latch.sv
// Purpose: Sticky event latch with clear and read-clear
// Assumes: Events are single-cycle or level conditions
// Notes: A set in the clear cycle survives the clear
`timescale 1ns/1ps
module isr_latch #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic [W-1:0] set_i,
  output logic [W-1:0] lat_o
);
  // Latched bits ignore the condition once set; unused bits stay zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lat_o <= '0;
    end else if (ce_i) begin
      lat_o <= ((clr_i ? '0 : lat_o) | set_i) & USED;
    end
  end
endmodule : isr_latch

//--- core/isr_pkg.sv
// Purpose: Shared constants for the instrument status reporting block
// Assumes: One system clock, synchronous active-high reset
// Notes: Bit positions are the zero-based bit numbers within each register
package isr_pkg;
  // Status summary bit positions
  localparam int SUM_QUES_BIT = 3;
  localparam int SUM_MAV_BIT = 4;
  localparam int SUM_ESB_BIT = 5;
  localparam int SUM_RQS_BIT = 6;
  // Standard event bit positions
  localparam int SE_OPC_BIT = 0;
  localparam int SE_QUERY_BIT = 2;
  localparam int SE_DEV_BIT = 3;
  localparam int SE_EXEC_BIT = 4;
  localparam int SE_CMD_BIT = 5;
  localparam int SE_PON_BIT = 7;
  // Questionable bit positions
  localparam int QD_VOLT_BIT = 0;
  localparam int QD_CURR_BIT = 1;
  localparam int QD_OHM_BIT = 9;
  localparam int QD_LO_BIT = 11;
  localparam int QD_HI_BIT = 12;
  // Masks of implemented bits
  localparam logic [7:0] SE_USED_MASK = 8'hbd;
  localparam logic [15:0] QD_USED_MASK = 16'h1a03;
  localparam logic [7:0] SUM_USED_MASK = 8'h78;
  // Reset values
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Power-on state machine
  typedef enum logic [1:0] {
    ISR_ST_PON = 2'b00,
    ISR_ST_RUN = 2'b01
  } isr_state_t;
endpackage : isr_pkg

//--- core/isr_status.sv
// Summary of operation
// - Enabled questionable events set summary bit 3
// - Summary bit 4 follows output buffer data
// - Enabled standard events set summary bit 5
// - Summary bit 6 is service request
// - Clearing events clears their summary bits
// - Clear-status clears event registers and their summary bits; bit 4 stays
// - Event read clears only its summary bit
// - Summary mask cleared by zero or power-on (power-on clears it only with psc_i 1)
// - Operation complete sets standard bit 0
// - Query errors set standard bit 2
// - Device errors and overload set bit 3
// - Exec bit 4, syntax bit 5, 1,6 zero
// - Power cycle sets standard bit 7
// - Clear-status or read clears standard events
// - Standard mask cleared by zero or power-on (power-on clears it only with psc_i 1)
// - Reset and device clear keep events
// - Range overloads set questionable 0, 1, 9
// - Limit failures set questionable 11, 12
// - Clear-status or query clears questionable events
// - Questionable mask cleared at power-on, preset, zero
// - Overload reported without error queue entry
// - Error queue entries set standard bits 2-5
// - Event bits are latched until cleared
// - Mask reads and clear-status keep masks
//
// Purpose: Status byte, standard event and questionable registers
// Assumes: Command decoder gives one-cycle strobes; psc_i is the stored
//   power-on-clear setting, valid at reset release
// Notes: sys_rst_i stands for power-on; standard and summary masks are held
//   across it when psc_i is 0
`timescale 1ns/1ps
module isr_status
  import isr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic psc_i,
  input wire logic cls_i,
  input wire logic se_read_i,
  input wire logic qd_read_i,
  input wire logic sre_wr_i,
  input wire logic ese_wr_i,
  input wire logic qde_wr_i,
  input wire logic preset_i,
  input wire logic [7:0] wdata_i,
  input wire logic outbuf_avail_i,
  input wire logic opc_done_i,
  input wire logic query_err_i,
  input wire logic selftest_fail_i,
  input wire logic cal_fail_i,
  input wire logic overload_i,
  input wire logic exec_err_i,
  input wire logic syntax_err_i,
  input wire logic volt_ovld_i,
  input wire logic curr_ovld_i,
  input wire logic ohm_ovld_i,
  input wire logic limit_lo_i,
  input wire logic limit_hi_i,
  input wire logic [15:0] qde_wdata_i,
  output logic [7:0] status_summary_o,
  output logic [7:0] standard_event_latch_o,
  output logic [15:0] questionable_event_latch_o,
  output logic [7:0] sre_mask_o,
  output logic [7:0] ese_mask_o,
  output logic [15:0] qde_mask_o,
  output logic rqs_o
);
  import isr_pkg::*;

  isr_state_t state_reg;
  logic pon_pulse;
  logic [7:0] se_set;
  logic [15:0] qd_set;
  logic [7:0] se_lat;
  logic [15:0] qd_lat;
  logic se_clr;
  logic qd_clr;
  logic ques_sum;
  logic esb_sum;
  logic [7:0] sum_next;
  logic [7:0] sum_base;
  logic [7:0] sre_reg;
  logic [7:0] ese_reg;
  logic [15:0] qde_reg;

  // Any enabled set bit; shared by both summary paths
  function automatic logic any_enabled16(input logic [15:0] ev,
                                         input logic [15:0] en);
    any_enabled16 = |(ev & en);
  endfunction : any_enabled16

  // One-hot mask of the request bit; it is kept out of its own request term
  function automatic logic [7:0] sum_rqs_mask();
    sum_rqs_mask = ZERO8;
    sum_rqs_mask[SUM_RQS_BIT] = 1'b1;
  endfunction : sum_rqs_mask

  // One pass through PON marks the first cycle after power-on
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= ISR_ST_PON;
    end else if (ce_i) begin
      state_reg <= ISR_ST_RUN;
    end
  end
  assign pon_pulse = (state_reg == ISR_ST_PON) && ce_i;

  // Event sources; overload feeds events only, no error queue path
  always_comb begin
    se_set = ZERO8;
    se_set[SE_OPC_BIT] = opc_done_i;
    se_set[SE_QUERY_BIT] = query_err_i;
    se_set[SE_DEV_BIT] = selftest_fail_i | cal_fail_i | overload_i;
    se_set[SE_EXEC_BIT] = exec_err_i;
    se_set[SE_CMD_BIT] = syntax_err_i;
    se_set[SE_PON_BIT] = pon_pulse;
    qd_set = ZERO16;
    qd_set[QD_VOLT_BIT] = volt_ovld_i;
    qd_set[QD_CURR_BIT] = curr_ovld_i;
    qd_set[QD_OHM_BIT] = ohm_ovld_i;
    qd_set[QD_LO_BIT] = limit_lo_i;
    qd_set[QD_HI_BIT] = limit_hi_i;
  end

  // Only clear-status or a read clears; reset command is not wired in
  assign se_clr = cls_i | se_read_i;
  assign qd_clr = cls_i | qd_read_i;

  isr_latch #(.W(8), .USED(SE_USED_MASK)) u_se (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .clr_i(se_clr),
    .set_i(se_set),
    .lat_o(se_lat)
  );

  isr_latch #(.W(16), .USED(QD_USED_MASK)) u_qd (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .clr_i(qd_clr),
    .set_i(qd_set),
    .lat_o(qd_lat)
  );

  // Questionable mask clears at every power-on, whatever the setting;
  // preset wins over a write that lands in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      qde_reg <= ZERO16;
    end else if (ce_i) begin
      if (preset_i) begin
        qde_reg <= ZERO16;
      end else if (qde_wr_i) begin
        qde_reg <= qde_wdata_i & QD_USED_MASK;
      end
    end
  end

  // Standard and summary masks survive power-on when psc_i is 0; no reset
  // branch, so in simulation they stay unknown until written or cleared by a power-on with psc_i 1
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (pon_pulse && psc_i) begin
        ese_reg <= ZERO8;
        sre_reg <= ZERO8;
      end else begin
        if (ese_wr_i) begin
          ese_reg <= wdata_i;
        end
        if (sre_wr_i) begin
          sre_reg <= wdata_i & SUM_USED_MASK;
        end
      end
    end
  end

  // Summary from the current latch values, so a latch clear drops its bit
  // on the next edge without a second bookkeeping path
  always_comb begin
    ques_sum = any_enabled16(qd_lat, qde_reg);
    esb_sum = any_enabled16({8'h00, se_lat}, {8'h00, ese_reg});
    sum_base = ZERO8;
    sum_base[SUM_QUES_BIT] = ques_sum;
    sum_base[SUM_MAV_BIT] = outbuf_avail_i;
    sum_base[SUM_ESB_BIT] = esb_sum;
    // Request built from a separate base so bit 6 can never hold itself on
    sum_next = sum_base;
    sum_next[SUM_RQS_BIT] = |(sum_base & sre_reg & ~sum_rqs_mask());
  end

  // Registered outputs; masks read back unchanged by reads and clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_summary_o <= ZERO8;
      standard_event_latch_o <= ZERO8;
      questionable_event_latch_o <= ZERO16;
      sre_mask_o <= ZERO8;
      ese_mask_o <= ZERO8;
      qde_mask_o <= ZERO16;
      rqs_o <= 1'b0;
    end else if (ce_i) begin
      status_summary_o <= sum_next;
      standard_event_latch_o <= se_lat;
      questionable_event_latch_o <= qd_lat;
      sre_mask_o <= sre_reg;
      ese_mask_o <= ese_reg;
      qde_mask_o <= qde_reg;
      rqs_o <= sum_next[SUM_RQS_BIT];
    end
  end

  // Assertions
  a_unused_zero: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) (status_summary_o & ~SUM_USED_MASK) == ZERO8)
    else $error("unused summary bit set");
  a_se_unused: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) (se_lat & ~SE_USED_MASK) == ZERO8)
    else $error("unused standard bit set");
  a_qd_unused: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) (qd_lat & ~QD_USED_MASK) == ZERO16)
    else $error("unused questionable bit set");
  a_se_latched: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && !se_clr && se_lat[SE_CMD_BIT]
    |=> se_lat[SE_CMD_BIT])
    else $error("standard bit lost without clear");
  a_cls_clears: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && cls_i && se_set == ZERO8 && qd_set == ZERO16
    |=> se_lat == ZERO8 && qd_lat == ZERO16)
    else $error("clear-status left events");
  a_syntax_set: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && syntax_err_i |=> se_lat[SE_CMD_BIT])
    else $error("syntax error not latched");
  a_ques_sum: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i |=> status_summary_o[SUM_QUES_BIT] ==
    $past(|(qd_lat & qde_reg)))
    else $error("questionable summary wrong");
  a_mav_follow: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i |=> status_summary_o[SUM_MAV_BIT] ==
    $past(outbuf_avail_i))
    else $error("message available wrong");
  a_rqs_match: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) rqs_o == status_summary_o[SUM_RQS_BIT])
    else $error("service request mismatch");
  a_mask_keep: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && cls_i && !preset_i && !qde_wr_i
    |=> qde_reg == $past(qde_reg))
    else $error("clear-status changed mask");
  a_pon_sets: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) pon_pulse |=> se_lat[SE_PON_BIT])
    else $error("power-on bit not latched");
  a_opc_set: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && opc_done_i |=> se_lat[SE_OPC_BIT])
    else $error("operation complete not latched");
  a_se_read_clr: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && se_read_i && se_set == ZERO8
    |=> se_lat == ZERO8)
    else $error("standard read left events");
  a_qd_read_clr: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && qd_read_i && qd_set == ZERO16
    |=> qd_lat == ZERO16)
    else $error("questionable query left events");
  a_qd_latched: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && !qd_clr && qd_lat[QD_LO_BIT]
    |=> qd_lat[QD_LO_BIT])
    else $error("questionable bit lost without clear");
  // The summary lags the latch by one enabled edge, hence the extra step
  a_esb_drop: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && se_clr && se_set == ZERO8 ##1 ce_i
    |=> !status_summary_o[SUM_ESB_BIT])
    else $error("standard summary kept after clear");
  a_ques_drop: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && qd_clr && qd_set == ZERO16 ##1 ce_i
    |=> !status_summary_o[SUM_QUES_BIT])
    else $error("questionable summary kept after clear");
  a_psc_clear: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) pon_pulse && psc_i
    |=> sre_reg == ZERO8 && ese_reg == ZERO8)
    else $error("masks kept with clear setting on");
  a_psc_keep: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) pon_pulse && !psc_i && !sre_wr_i && !ese_wr_i
    |=> sre_reg == $past(sre_reg) && ese_reg == $past(ese_reg))
    else $error("masks lost with clear setting off");
  a_qde_pon: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) $fell(sys_rst_i) |-> qde_reg == ZERO16)
    else $error("questionable mask kept over power-on");
  a_preset_clr: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) ce_i && preset_i |=> qde_reg == ZERO16)
    else $error("preset left questionable mask");
  a_rqs_cause: assert property (@(posedge clk_sys_i) disable iff
    (sys_rst_i) rqs_o ==
    |(status_summary_o & sre_mask_o & ~sum_rqs_mask()))
    else $error("service request without enabled cause");

  // Main scenarios
  c_rqs: cover property (@(posedge clk_sys_i) rqs_o);
  c_read_clr: cover property (@(posedge clk_sys_i) se_read_i &&
    se_lat != ZERO8);
  c_cls: cover property (@(posedge clk_sys_i) cls_i && qd_lat != ZERO16);
  c_ques_sum: cover property (@(posedge clk_sys_i)
    status_summary_o[SUM_QUES_BIT]);
  c_psc_keep: cover property (@(posedge clk_sys_i) pon_pulse && !psc_i);
endmodule : isr_status

//--- verif/isr_host_model.sv
// Purpose: Remote controller model issuing status command strobes
// Assumes: One strobe per command, one clock wide, launched at falling edge
// Notes: Data lines show the inverse once a write is over
`timescale 1ns/1ps
module isr_host_model (
  input wire logic clk_sys_i,
  output logic [6:0] cmd_o,
  output logic [15:0] data_o
);
  // Idle bus at time zero
  initial begin
    cmd_o = 7'h00;
    data_o = 16'h0000;
  end
  // Bit c of cmd_o is the strobe; a released bus never keeps stale data
  task automatic issue(input int c, input logic [15:0] d);
    @(negedge clk_sys_i);
    cmd_o = 7'h01 << c;
    data_o = d;
    @(negedge clk_sys_i);
    cmd_o = 7'h00;
    data_o = ~d;
  endtask : issue
endmodule : isr_host_model

//--- verif/test_isr_status.sv
// Purpose: Self-checking bench for the status reporting block
// Assumes: Outputs settle two edges after a taken strobe or event
// Notes: Commands 0 clear,1 std read,2 ques read,3-5 mask writes,6 preset
`timescale 1ns/1ps
module test_isr_status;
  import isr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psc_i = 1'b1;
  logic ob = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [6:0] cmd;
  logic [15:0] data, qd, qdem;
  logic [7:0] sum, se, srem, esem;
  logic rqs;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] wt [12] = '{16'h01, 16'h04, 16'h08, 16'h08, 16'h08, 16'h10,
    16'h20, 16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};
  isr_host_model host (.clk_sys_i(clk_sys_i), .cmd_o(cmd), .data_o(data));
  isr_status dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .psc_i(psc_i), .cls_i(cmd[0]), .se_read_i(cmd[1]), .qd_read_i(cmd[2]),
    .sre_wr_i(cmd[3]), .ese_wr_i(cmd[4]), .qde_wr_i(cmd[5]),
    .preset_i(cmd[6]), .wdata_i(data[7:0]), .outbuf_avail_i(ob),
    .opc_done_i(ev[0]), .query_err_i(ev[1]), .selftest_fail_i(ev[2]),
    .cal_fail_i(ev[3]), .overload_i(ev[4]), .exec_err_i(ev[5]),
    .syntax_err_i(ev[6]), .volt_ovld_i(ev[7]), .curr_ovld_i(ev[8]),
    .ohm_ovld_i(ev[9]), .limit_lo_i(ev[10]), .limit_hi_i(ev[11]),
    .qde_wdata_i(data), .status_summary_o(sum),
    .standard_event_latch_o(se), .questionable_event_latch_o(qd),
    .sre_mask_o(srem), .ese_mask_o(esem), .qde_mask_o(qdem), .rqs_o(rqs));
  // 40 MHz clock and a cycle ceiling against hangs
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wait_n
  task automatic pulse(input int i);
    @(negedge clk_sys_i);
    ev[i] = 1'b1;
    @(negedge clk_sys_i);
    ev[i] = 1'b0;
    wait_n(3);
  endtask : pulse
  task automatic cmd_wait(input int c, input logic [15:0] d);
    host.issue(c, d);
    wait_n(3);
  endtask : cmd_wait
  task automatic power_on(input logic p);
    psc_i = p;
    sys_rst_i = 1'b1;
    wait_n(12);
    sys_rst_i = 1'b0;
    wait_n(4);
    chk(16'(se), 16'h80);
    chk(16'(sum), 16'h00);
    chk(qdem, 16'h0000);
  endtask : power_on
  // Each standard event alone, then the read that clears it
  task automatic t_std_events();
    cmd_wait(1, 16'h0);
    chk(16'(se), 16'h00);
    chk({esem, srem}, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      chk(16'(se), wt[i]);
      cmd_wait(1, 16'h0);
      chk(16'(se), 16'h00);
    end
  endtask : t_std_events
  task automatic t_ques_events();
    for (int i = 7; i < 12; i++) begin
      pulse(i);
      chk(qd, wt[i]);
      cmd_wait(2, 16'h0);
      chk(qd, 16'h0000);
    end
  endtask : t_ques_events
  // Level held then dropped stays latched; a frozen clock enable ignores
  task automatic t_latch();
    ev[10] = 1'b1;
    wait_n(5);
    ev[10] = 1'b0;
    wait_n(3);
    chk(qd, 16'h0800);
    ce_i = 1'b0;
    pulse(5);
    ce_i = 1'b1;
    wait_n(2);
    chk(16'(se), 16'h00);
    cmd_wait(2, 16'h0);
  endtask : t_latch
  task automatic t_summary();
    cmd_wait(4, 16'h0020);
    cmd_wait(3, 16'h0038);
    cmd_wait(5, 16'h1a03);
    chk({esem, srem}, 16'h2038);
    pulse(6);
    pulse(10);
    ob = 1'b1;
    wait_n(3);
    chk(16'(sum), 16'h78);
    chk(16'(rqs), 16'h1);
    cmd_wait(1, 16'h0);
    chk(16'(sum), 16'h58);
    cmd_wait(0, 16'h0);
    chk(qd, 16'h0000);
    chk(16'(se), 16'h00);
    chk(16'(sum), 16'h50);
    chk(16'(esem), 16'h20);
    chk(qdem, 16'h1a03);
    ob = 1'b0;
    wait_n(3);
    chk(16'(sum), 16'h00);
  endtask : t_summary
  // Power cycle with the clear setting off keeps two masks only
  task automatic t_repower();
    power_on(1'b0);
    chk({esem, srem}, 16'h2038);
    cmd_wait(5, 16'h0a00);
    chk(qdem, 16'h0a00);
    cmd_wait(6, 16'h0);
    chk(qdem, 16'h0000);
    cmd_wait(4, 16'h0);
    cmd_wait(3, 16'h0);
    chk({esem, srem}, 16'h0000);
  endtask : t_repower
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    power_on(1'b1);
    t_std_events();
    t_ques_events();
    t_latch();
    t_summary();
    t_repower();
    conclude();
  end
endmodule : test_isr_status
